// ===== common/vsp_pkg.sv
package vsp_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_SEP_THRESH = 8'h11;
  localparam logic [7:0] ADDR_FILT_STATUS = 8'h16;
  localparam logic [7:0] ADDR_SLICER_LEVEL = 8'h1d;
  localparam logic [7:0] ADDR_FILT_WINDOW = 8'h20;
  localparam logic [7:0] ADDR_PATH_SELECT = 8'h21;
  localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h23;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h24;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SLICER_LSB = 3;
  localparam int SEL_VFILT_BIT = 5;
  localparam int SEL_PLL_FILT_BIT = 6;
  localparam int SEL_REGEN_BIT = 7;
  localparam int OUT_POL_BIT = 7;
  localparam int STAT_EXTRA_BIT = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SEP_THRESH = 8'h20;
  localparam logic [7:0] RST_SLICER_LEVEL = 8'h78;
  localparam logic [7:0] RST_FILT_WINDOW = 8'h0a;
  localparam logic [7:0] RST_PATH_SELECT = 8'he0;
  localparam logic [7:0] RST_SYNC_WIDTH = 8'h20;
  localparam logic [7:0] RST_OUT_CTRL = 8'h80;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEP_TICK_NS = 200;
  localparam int SEP_TICK_CYC = SEP_TICK_NS / CLK_PERIOD_NS;
  localparam int WIN_UNIT_NS = 25;
  localparam int WIN_UNIT_CYC = (WIN_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VF_GUARD_CYC = 2;
  // ----------------------------------------
  // Separator states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEP_HUNT = 3'b001,
    SEP_HOLD = 3'b010,
    SEP_TAIL = 3'b100
  } vsp_sep_t;
endpackage

// ===== rtl/vsp_sync_processor.sv
`timescale 1ns/1ps
// Summary of operation
// - Slicer trigger level from register bits 7:3
// - Threshold N sets minimum pulse, N*200ns
// - Separator is 8-bit counter at separator tick
// - Separator ignores composite sync polarity
// - Count up during pulse, down after, stop 0
// - Vertical sync present when count exceeds N
// - Clear on detect, count after end, release
// - Output vertical sync lags by threshold time
// - Composite source: slicer or line sync input
// - Window plus/minus x*25ns around regenerated edge
// - Drop pulses outside window, pass clean sync
// - Status bit reports extraneous pulses
// - Select bit 6 picks PLL reference
// - Select bit 7 picks processing sync
// - Regenerator free-runs, tolerates missing pulses
// - Regenerated sync for counting, not PLL
// - Filtered vertical leading edge never on line_sync_output leading edge
// - Select bit 5 enables vertical filter
// - Vertical filter yields odd/even field flag
// - Output line sync polarity from bit 7
// - Output line sync width in pixel clocks
module vsp_sync_processor #(
  parameter int CNT_W = 8,
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pixClkEn,
  // Raw sync inputs, already polarity-resolved
  input wire logic lineSyncIn,
  input wire logic greenSyncIn,
  input wire logic useGreenSync,
  // Register port
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Outputs
  output logic [4:0] slicerLevel,
  output logic pllRefSync,
  output logic regenLineSync,
  output logic line_sync_output,
  output logic frame_sync_output,
  output logic oddField
);
  import vsp_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] lineMeta, greenMeta; // Two-stage chains
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lineMeta <= '0;
      greenMeta <= '0;
    end else begin
      lineMeta <= {lineMeta[0], lineSyncIn};
      greenMeta <= {greenMeta[0], greenSyncIn};
    end
  end
  logic lineS, greenS;
  assign lineS = lineMeta[1];
  assign greenS = greenMeta[1];
  logic compSync; // Composite source
  assign compSync = useGreenSync ? greenS : lineS;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] sepThresh_reg, slicer_reg, window_reg, select_reg, width_reg, outCtrl_reg;
  logic extraFlag_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sepThresh_reg <= RST_SEP_THRESH;
      slicer_reg <= RST_SLICER_LEVEL;
      window_reg <= RST_FILT_WINDOW;
      select_reg <= RST_PATH_SELECT;
      width_reg <= RST_SYNC_WIDTH;
      outCtrl_reg <= RST_OUT_CTRL;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_SEP_THRESH: sepThresh_reg <= regWrData;
        ADDR_SLICER_LEVEL: slicer_reg <= regWrData;
        ADDR_FILT_WINDOW: window_reg <= regWrData;
        ADDR_PATH_SELECT: select_reg <= regWrData;
        ADDR_SYNC_WIDTH: width_reg <= regWrData;
        ADDR_OUT_CTRL: outCtrl_reg <= regWrData;
        default: ;
      endcase
    end
  end
  // Read mux
  always_comb begin
    case (regAddr)
      ADDR_SEP_THRESH: regRdData = sepThresh_reg;
      ADDR_FILT_STATUS: regRdData = {7'h00, extraFlag_reg};
      ADDR_SLICER_LEVEL: regRdData = slicer_reg;
      ADDR_FILT_WINDOW: regRdData = window_reg;
      ADDR_PATH_SELECT: regRdData = select_reg;
      ADDR_SYNC_WIDTH: regRdData = width_reg;
      ADDR_OUT_CTRL: regRdData = outCtrl_reg;
      default: regRdData = 8'h00;
    endcase
  end
  assign slicerLevel = slicer_reg[7:SLICER_LSB];

  // ----------------------------------------
  // Separator tick divider
  // ----------------------------------------
  logic [3:0] tickDiv_reg;
  logic sepTick;
  assign sepTick = (tickDiv_reg == 4'(SEP_TICK_CYC - 1));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) tickDiv_reg <= '0;
    else tickDiv_reg <= sepTick ? 4'h0 : tickDiv_reg + 4'h1;
  end

  // ----------------------------------------
  // Sync separator
  // ----------------------------------------
  vsp_sep_t sepState_reg;
  logic [CNT_W-1:0] sepCnt_reg;
  logic sepVsync_reg;
  logic [CNT_W-1:0] thr;
  assign thr = CNT_W'(sepThresh_reg);
  // Counter works on pulse level only, polarity already resolved upstream
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sepState_reg <= SEP_HUNT;
      sepCnt_reg <= '0;
      sepVsync_reg <= 1'b0;
    end else if (sepTick) begin
      case (sepState_reg)
        SEP_HUNT: begin
          if (sepCnt_reg > thr) begin
            sepVsync_reg <= 1'b1;
            sepCnt_reg <= '0;
            sepState_reg <= SEP_HOLD;
          end else if (compSync) begin
            if (sepCnt_reg != '1) sepCnt_reg <= sepCnt_reg + 1'b1;
          end else if (sepCnt_reg != '0) begin
            sepCnt_reg <= sepCnt_reg - 1'b1;
          end
        end
        SEP_HOLD: begin
          // Wait for pulse end; serrations restart the count
          if (!compSync) sepState_reg <= SEP_TAIL;
        end
        SEP_TAIL: begin
          if (compSync) begin
            sepCnt_reg <= '0;
            sepState_reg <= SEP_HOLD;
          end else if (sepCnt_reg >= thr) begin
            sepVsync_reg <= 1'b0;
            sepCnt_reg <= '0;
            sepState_reg <= SEP_HUNT;
          end else begin
            sepCnt_reg <= sepCnt_reg + 1'b1;
          end
        end
        default: sepState_reg <= SEP_HUNT;
      endcase
    end
  end

  // ----------------------------------------
  // Line sync regenerator (period tracker)
  // ----------------------------------------
  logic lineD_reg;
  logic lineRise;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) lineD_reg <= 1'b0;
    else lineD_reg <= compSync;
  end
  assign lineRise = compSync & ~lineD_reg;
  logic [PERIOD_W-1:0] phase_reg, period_reg;
  logic [PERIOD_W-1:0] winCyc;
  assign winCyc = PERIOD_W'(window_reg) * PERIOD_W'(WIN_UNIT_CYC);
  logic inWindow, regenEdge;
  assign regenEdge = (period_reg != '0) && (phase_reg == period_reg - 1'b1);
  assign inWindow = (phase_reg <= winCyc) || (phase_reg + winCyc >= period_reg - 1'b1);
  logic [PERIOD_W-1:0] rawGap_reg; // Cycles since last raw edge, saturating
  logic [PERIOD_W-1:0] prevGap_reg; // Previous raw spacing, all ones when unknown
  logic gapMatch; // Two raw spacings alike within the window
  assign gapMatch = (prevGap_reg != '1) && (rawGap_reg != '1) &&
    (rawGap_reg + winCyc >= prevGap_reg) && (rawGap_reg <= prevGap_reg + winCyc);
  // Raw edge spacing; lets the flywheel learn or relearn the line rate
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rawGap_reg <= '0;
      prevGap_reg <= '1;
    end else if (lineRise) begin
      rawGap_reg <= '0;
      prevGap_reg <= rawGap_reg;
    end else if (rawGap_reg != '1) begin
      rawGap_reg <= rawGap_reg + 1'b1;
    end
  end
  // Flywheel: realign on expected edges, relock only on a steady rate,
  // free-runs through gaps and stray edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= '0;
      period_reg <= '0;
    end else if (lineRise && period_reg != '0 && inWindow) begin
      phase_reg <= '0; // Expected edge
    end else if (lineRise && gapMatch) begin
      period_reg <= rawGap_reg + 1'b1; // Steady rate seen twice
      phase_reg <= '0;
    end else if (regenEdge) begin
      phase_reg <= '0;
    end else if (phase_reg != '1) begin
      phase_reg <= phase_reg + 1'b1;
    end else begin
      period_reg <= '0; // Lost lock
    end
  end
  logic regen_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) regen_reg <= 1'b0;
    else regen_reg <= regenEdge | (lineRise & (period_reg == '0));
  end
  assign regenLineSync = regen_reg;

  // ----------------------------------------
  // Line sync filter and status
  // ----------------------------------------
  logic filtLine_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) filtLine_reg <= 1'b0;
    else if (compSync && !inWindow && period_reg != '0) filtLine_reg <= filtLine_reg;
    else filtLine_reg <= compSync;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) extraFlag_reg <= 1'b0;
    else if (lineRise && period_reg != '0) extraFlag_reg <= !inWindow;
    else if (regenEdge && !lineRise) extraFlag_reg <= extraFlag_reg;
  end
  logic pllRef_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) pllRef_reg <= 1'b0;
    else pllRef_reg <= select_reg[SEL_PLL_FILT_BIT] ? filtLine_reg : compSync;
  end
  assign pllRefSync = pllRef_reg;
  logic procLine;
  assign procLine = select_reg[SEL_REGEN_BIT] ? regen_reg : lineRise;

  // ----------------------------------------
  // Vertical sync filter and field flag
  // ----------------------------------------
  logic [PERIOD_W-1:0] sinceLine_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sinceLine_reg <= '0;
    else if (procLine) sinceLine_reg <= '0;
    else if (sinceLine_reg != '1) sinceLine_reg <= sinceLine_reg + 1'b1;
  end
  logic sepD_reg, vPend_reg, vOut_reg, odd_reg;
  logic guardBusy;
  assign guardBusy = procLine || sinceLine_reg < PERIOD_W'(VF_GUARD_CYC);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sepD_reg <= 1'b0;
    else sepD_reg <= sepVsync_reg;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vPend_reg <= 1'b0;
      vOut_reg <= 1'b0;
      odd_reg <= 1'b0;
    end else if (!select_reg[SEL_VFILT_BIT]) begin
      vOut_reg <= sepVsync_reg;
      vPend_reg <= 1'b0;
    end else begin
      if (sepVsync_reg && !sepD_reg) begin
        vPend_reg <= 1'b1;
        // Mid-line vertical edge marks the second field
        odd_reg <= (sinceLine_reg > (period_reg >> 2)) && (sinceLine_reg < period_reg - (period_reg >> 2));
      end else if (vPend_reg && !guardBusy) begin
        vOut_reg <= 1'b1;
        vPend_reg <= 1'b0;
      end
      if (!sepVsync_reg && !vPend_reg) vOut_reg <= 1'b0;
    end
  end
  assign oddField = odd_reg;
  assign frame_sync_output = vOut_reg;

  // ----------------------------------------
  // Output line sync width and polarity
  // ----------------------------------------
  logic [7:0] widthCnt_reg;
  logic outPulse_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      widthCnt_reg <= '0;
      outPulse_reg <= 1'b0;
    end else if (procLine) begin
      widthCnt_reg <= width_reg;
      outPulse_reg <= (width_reg != 8'h00);
    end else if (pixClkEn && widthCnt_reg != 8'h00) begin
      widthCnt_reg <= widthCnt_reg - 8'h01;
      outPulse_reg <= (widthCnt_reg != 8'h01);
    end
  end
  logic lineOut_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) lineOut_reg <= 1'b0;
    else lineOut_reg <= outPulse_reg ^ ~outCtrl_reg[OUT_POL_BIT];
  end
  assign line_sync_output = lineOut_reg;
endmodule // vsp_sync_processor

// ===== tb/vsp_sync_processor_checker.sv
`timescale 1ns/1ps
module vsp_sync_processor_checker
  import vsp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Sync inputs
  input wire logic lineSyncIn,
  input wire logic greenSyncIn,
  input wire logic useGreenSync,
  // Register port
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // Outputs
  input wire logic [4:0] slicerLevel,
  input wire logic regenLineSync,
  input wire logic line_sync_output,
  input wire logic frame_sync_output
);
  logic [7:0] riseAge; // Cycles since selected source rose
  wire logic src = useGreenSync ? greenSyncIn : lineSyncIn; // Selected source
  wire logic slWr = regWrite && (regAddr == ADDR_SLICER_LEVEL); // Slicer level write
  // --------------------------------
  // Helper counter
  // --------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      riseAge <= 8'h00;
    end else if ($rose(src)) begin
      riseAge <= 8'h00;
    end else if (riseAge != 8'hff) begin
      riseAge <= riseAge + 8'h01;
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_vs_held;
    frame_sync_output [*8];
  endsequence
  a_vs_late: assert property ($rose(frame_sync_output) |-> riseAge >= 8'd8)
    else $error("frame sync from short pulse");
  a_vs_hold: assert property ($rose(frame_sync_output) |-> s_vs_held)
    else $error("frame sync released too soon");
  a_sl_write: assert property (slWr |-> ##2 slicerLevel == $past(regWrData[7:3], 2))
    else $error("slicer level not updated");
  a_sl_stable: assert property (!slWr [*3] |=> $stable(slicerLevel))
    else $error("slicer level moved without write");
  a_sl_reset: assert property ($fell(reset) |-> ##[1:2] slicerLevel == RST_SLICER_LEVEL[7:3])
    else $error("slicer level reset value wrong");
  a_rd_unmapped: assert property (regAddr == 8'h00 |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_pol_idle: assert property ($fell(reset) |-> ##2 line_sync_output == !RST_OUT_CTRL[OUT_POL_BIT])
    else $error("line sync idle level wrong");
  a_regen_pulse: assert property (regenLineSync |=> !regenLineSync)
    else $error("regenerated pulse too long");
endmodule // vsp_sync_processor_checker

bind vsp_sync_processor vsp_sync_processor_checker chk (.ref_clk, .reset, .lineSyncIn, .greenSyncIn,
  .useGreenSync, .regWrite, .regAddr, .regWrData, .regRdData, .slicerLevel, .regenLineSync,
  .line_sync_output, .frame_sync_output);

// ===== tb/vsp_sync_source.sv
`timescale 1ns/1ps
module vsp_sync_source (
  // Clock
  input wire logic ref_clk,
  // Commands
  input wire logic lineEn,
  input wire logic longReq,
  input wire logic useGreen,
  // Sync lines
  output logic lineSyncIn,
  output logic greenSyncIn,
  output logic pixClkEn
);
  logic [7:0] phase = 8'h00; // 256-cycle line period
  logic comp; // Composite sync, active high
  initial pixClkEn = 1'b0;
  // Line phase and pixel enable, off the sampling edge
  always @(negedge ref_clk) begin
    phase <= phase + 8'h01;
    pixClkEn <= ~pixClkEn;
  end
  // 20-cycle line pulses, or one long frame pulse
  assign comp = longReq || (lineEn && phase < 8'd20);
  // Unselected line carries the inverse, mostly high
  assign lineSyncIn = useGreen ? ~comp : comp;
  assign greenSyncIn = useGreen ? comp : ~comp;
endmodule // vsp_sync_source

// ===== tb/vsp_sync_processor_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nErrors++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module vsp_sync_processor_tb;
  import vsp_pkg::*;
  logic ref_clk, reset, pixClkEn, lineSyncIn, greenSyncIn, useGreenSync, regWrite;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [4:0] slicerLevel;
  logic pllRefSync, regenLineSync, line_sync_output, frame_sync_output, oddField;
  logic lineEn, longReq, seen; // Source commands, sticky flag
  int nErrors = 0;
  int nTests = 0;
  int t;
  int n; // Regenerated pulses counted
  vsp_sync_processor uut (.ref_clk(ref_clk), .reset(reset), .pixClkEn(pixClkEn),
    .lineSyncIn(lineSyncIn), .greenSyncIn(greenSyncIn), .useGreenSync(useGreenSync),
    .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .slicerLevel(slicerLevel), .pllRefSync(pllRefSync), .regenLineSync(regenLineSync),
    .line_sync_output(line_sync_output), .frame_sync_output(frame_sync_output), .oddField(oddField));
  vsp_sync_source src (.ref_clk(ref_clk), .lineEn(lineEn), .longReq(longReq), .useGreen(useGreenSync),
    .lineSyncIn(lineSyncIn), .greenSyncIn(greenSyncIn), .pixClkEn(pixClkEn));
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask
  // Combinational read, sampled mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    regAddr = a;
    #5;
    `CHK(regRdData, e)
  endtask
  // Verdict and end of run
  task automatic finishTest;
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Watchdog, about three times the expected run
  initial begin
    #1000000;
    nErrors++;
    $display("ERROR %0t: timeout", $time);
    finishTest;
  end
  initial begin
    reset = 1'b1;
    {regWrite, regAddr, regWrData, lineEn, longReq, useGreenSync} = '0;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    // Reset values and read-only status
    `CHK(slicerLevel, RST_SLICER_LEVEL[7:3])
    rd(ADDR_SEP_THRESH, RST_SEP_THRESH);
    rd(ADDR_SLICER_LEVEL, RST_SLICER_LEVEL);
    rd(ADDR_FILT_WINDOW, RST_FILT_WINDOW);
    rd(ADDR_PATH_SELECT, RST_PATH_SELECT);
    rd(ADDR_SYNC_WIDTH, RST_SYNC_WIDTH);
    rd(ADDR_OUT_CTRL, RST_OUT_CTRL);
    wr(ADDR_FILT_STATUS, 8'h55);
    rd(ADDR_FILT_STATUS, 8'h00);
    $display("test registers done");
    // Slicer level field
    wr(ADDR_SLICER_LEVEL, 8'ha8);
    repeat (2) @(negedge ref_clk);
    `CHK(slicerLevel, 5'h15)
    rd(ADDR_SLICER_LEVEL, 8'ha8);
    // Output polarity, both settings, no traffic
    wr(ADDR_OUT_CTRL, 8'h00);
    repeat (4) @(negedge ref_clk);
    `CHK(line_sync_output, 1'b1)
    wr(ADDR_OUT_CTRL, 8'h80);
    repeat (4) @(negedge ref_clk);
    `CHK(line_sync_output, 1'b0)
    $display("test polarity done");
    // Separator on each source; raw paths, then recommended paths
    wr(ADDR_SEP_THRESH, 8'h04);
    for (int s = 0; s < 4; s++) begin
      useGreenSync = s[0];
      wr(ADDR_PATH_SELECT, s[1] ? 8'he0 : 8'h20);
      lineEn = 1'b1;
      repeat (768) @(negedge ref_clk);
      rd(ADDR_FILT_STATUS, 8'h00);
      seen = 1'b0;
      repeat (1536) begin
        @(negedge ref_clk);
        seen = seen | frame_sync_output;
      end
      `CHK(seen, 1'b0)
      // Output line pulse width, two cycles per pixel enable
      while (src.phase != 8'd100) @(negedge ref_clk);
      t = 0;
      while (line_sync_output !== 1'b1 && t < 300) begin
        @(negedge ref_clk);
        t++;
      end
      t = 0;
      while (line_sync_output === 1'b1 && t < 300) begin
        @(negedge ref_clk);
        t++;
      end
      `CHK((t >= 2 * RST_SYNC_WIDTH - 1) && (t <= 2 * RST_SYNC_WIDTH), 1'b1)
      // Long pulse mid-line, outside the filter window
      while (src.phase != 8'd128) @(negedge ref_clk);
      lineEn = 1'b0;
      longReq = 1'b1;
      t = 0;
      while (frame_sync_output !== 1'b1 && t < 200) begin
        @(negedge ref_clk);
        t++;
      end
      `CHK((t >= 4 * SEP_TICK_CYC) && (t <= 6 * SEP_TICK_CYC + 4), 1'b1)
      `CHK(pllRefSync, s[1] ? 1'b0 : 1'b1)
      `CHK(oddField, s[1] ? 1'b1 : 1'b0)
      rd(ADDR_FILT_STATUS, 8'h01);
      n = 0;
      repeat (600) begin
        @(negedge ref_clk);
        if (regenLineSync === 1'b1) n++;
      end
      `CHK(frame_sync_output, 1'b1)
      `CHK((n >= 2) && (n <= 3), 1'b1)
      longReq = 1'b0;
      t = 0;
      while (frame_sync_output !== 1'b0 && t < 200) begin
        @(negedge ref_clk);
        t++;
      end
      `CHK((t >= 3 * SEP_TICK_CYC) && (t <= 6 * SEP_TICK_CYC + 4), 1'b1)
      $display("test separator source %0d done", s);
    end
    finishTest;
  end
endmodule // vsp_sync_processor_tb
